// ### shared/dma_addr_gen_defines.vh
// constants for the dma address generator
`ifndef DMA_ADDR_GEN_DEFINES_VH
`define DMA_ADDR_GEN_DEFINES_VH

// register indexes on the plain register port
`define REG_CTRL        4'h0
`define REG_OFFSET_0    4'h1
`define REG_SRC_ADDR    4'h5
`define REG_DST_ADDR    4'h6
`define REG_COUNT       4'h7
`define REG_STATUS      4'h8

// channel_control_reg fields
`define CTRL_AMF_HI     5
`define CTRL_AMF_LO     0
`define CTRL_3D_BIT     6
`define CTRL_EN_BIT     7
`define CTRL_W          7

// status fields
`define ST_ACTIVE_BIT   0
`define ST_ERR_BIT      1
`define ST_CMODE_LO     2
`define ST_SRC_KIND_LO  5
`define ST_DST_KIND_LO  7

// side update kinds
`define KIND_HOLD       2'h0
`define KIND_INC        2'h1
`define KIND_2D         2'h2
`define KIND_3D         2'h3

// counter modes
`define CM_A            3'h0
`define CM_B            3'h1
`define CM_C            3'h2
`define CM_D            3'h3
`define CM_E            3'h4
`define CM_RES          3'h7

// low and middle section widths per counter mode
`define LW_A            5'h18
`define LW_B            5'h0c
`define LW_CD           5'h06
`define LW_E            5'h0c
`define MW_AB           5'h00
`define MW_CE           5'h06
`define MW_D            5'h0c

// offset pair selections
`define OFF_0           2'h0
`define OFF_1           2'h1
`define OFF_2           2'h2
`define OFF_3           2'h3

`define RST_ZERO_24     24'h00_0000
`define ALL_ONES_24     24'hff_ffff

`endif

// ### src/addr_stepper.v
// next address of one side for one transferred word
`timescale 1ns/100ps
`default_nettype none
`include "dma_addr_gen_defines.vh"

module addr_stepper
#(
    parameter AW = 24
)
(
    input  wire [1:0]    i_kind,
    input  wire [AW-1:0] i_addr,
    input  wire [AW-1:0] i_off_a,
    input  wire [AW-1:0] i_off_b,
    input  wire          i_wrap_lo,
    input  wire          i_wrap_hi,
    output reg  [AW-1:0] o_next
);

always @*
begin
    o_next = i_addr;
    case (i_kind)
        `KIND_HOLD:
            o_next = i_addr; // RQ8
        `KIND_INC:
            o_next = i_addr + {{(AW-1){1'b0}}, 1'b1}; // RQ9
        `KIND_2D:
        begin
            // one offset on every end of an inner run
            if (i_wrap_lo || i_wrap_hi)
                o_next = i_addr + i_off_a; // RQ10 RQ16
            else
                o_next = i_addr + {{(AW-1){1'b0}}, 1'b1};
        end
        default:
        begin
            if (i_wrap_hi)
                o_next = i_addr + i_off_b; // RQ15 RQ16
            else if (i_wrap_lo)
                o_next = i_addr + i_off_a; // RQ15
            else
                o_next = i_addr + {{(AW-1){1'b0}}, 1'b1};
        end
    endcase
end

endmodule
`default_nettype wire

// ### src/dma_address_generator.v
// dma channel address generation and counter partitioning
`timescale 1ns/100ps
`default_nettype none
`include "dma_addr_gen_defines.vh"

// Behaviour
// RQ1 - control holds six-bit mode, two meanings
// RQ2 - non-3D: bits 5-3 dest, 2-0 source
// RQ3 - independent sides share one counter
// RQ4 - non-3D codes: 2D, hold, increment, reserved
// RQ5 - mixed counter modes run as mode B
// RQ6 - mode A: one undivided 24-bit count
// RQ7 - mode B: 12-bit outer, 12-bit inner
// RQ8 - hold mode keeps one address
// RQ9 - increment mode adds one per access
// RQ10 - 2D: run, add offset, repeat
// RQ11 - 3D: mode, side select, counter mode
// RQ12 - 3D upper code adds 3D pairs
// RQ13 - side select picks 3D side, pair
// RQ14 - 3D counter splits 12/6/6, 6/12/6, 6/6/12
// RQ15 - 3D: low run, first offset, then second
// RQ16 - 2D uses one offset, 3D two
// RQ17 - other side may reuse any offset
// RQ18 - four 24-bit read/write offset registers
// RQ19 - each side updates once per word
module dma_address_generator
#(
    parameter AW = 24,
    parameter CW = 24
)
(
    input  wire          i_clock,
    input  wire          i_nrst,
    input  wire [3:0]    i_addr,
    input  wire [23:0]   i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output wire [23:0]   o_rdata,
    input  wire          i_word_done,
    output wire [AW-1:0] o_src_addr,
    output wire [AW-1:0] o_dst_addr,
    output wire          o_active,
    output wire          o_done
);

reg  [`CTRL_W-1:0] ctrl_r;
reg  [AW-1:0]      off_r [0:3];
reg  [AW-1:0]      addr_r [0:1];
reg  [CW-1:0]      count_r;
reg  [CW-1:0]      work_r;
reg                active_r;
reg                err_r;
reg                done_r;
reg  [23:0]        rdata_r;
reg                run_pend_r;

wire [5:0] amf = ctrl_r[`CTRL_AMF_HI:`CTRL_AMF_LO];
wire       three_dim_select = ctrl_r[`CTRL_3D_BIT];

// decoded per-side selections, side 0 is source, side 1 destination
reg  [3:0] kind_s;
reg  [3:0] offa_s;
reg  [3:0] offb_s;
reg  [2:0] cmode_s;
reg        res_s;

// {reserved, kind, offset a, offset b} for one three-bit code
function [6:0] decode_code;
    input [2:0] c;
    input       in_3d;
    begin
        decode_code = {1'b0, `KIND_2D, c[1:0], c[1:0]}; // RQ4 RQ12
        if (c == 3'h4)
            decode_code = {1'b0, `KIND_HOLD, `OFF_0, `OFF_0};
        else if (c == 3'h5)
            decode_code = {1'b0, `KIND_INC, `OFF_0, `OFF_0};
        else if (c[2:1] == 2'h3 && !in_3d)
            decode_code = {1'b1, `KIND_HOLD, `OFF_0, `OFF_0}; // RQ4
        else if (c == 3'h6)
            decode_code = {1'b0, `KIND_3D, `OFF_0, `OFF_1}; // RQ12
        else if (c == 3'h7)
            decode_code = {1'b0, `KIND_3D, `OFF_2, `OFF_3}; // RQ12
    end
endfunction

reg [6:0] dec_src;
reg [6:0] dec_dst;
reg [6:0] dec_up;

always @*
begin
    dec_src = decode_code(amf[2:0], 1'b0);
    dec_dst = decode_code(amf[5:3], 1'b0);
    dec_up  = decode_code(amf[5:3], 1'b1);
    kind_s  = 4'h0;
    offa_s  = 4'h0;
    offb_s  = 4'h0;
    cmode_s = `CM_A;
    res_s   = 1'b0;
    if (!three_dim_select) // RQ1
    begin
        // two independent codes on one shared counter
        kind_s = {dec_dst[5:4], dec_src[5:4]}; // RQ2 RQ3
        offa_s = {dec_dst[3:2], dec_src[3:2]};
        offb_s = {dec_dst[1:0], dec_src[1:0]};
        res_s  = dec_src[6] | dec_dst[6];
        if (dec_src[5:4] == `KIND_2D || dec_dst[5:4] == `KIND_2D)
            cmode_s = `CM_B; // RQ5
        else
            cmode_s = `CM_A; // RQ6
    end
    else
    begin
        // the upper code steers the side that is not forced to 3D
        if (!amf[2]) // RQ11 RQ13
        begin
            kind_s = {dec_up[5:4], `KIND_3D};
            offa_s = {dec_up[3:2], `OFF_0};
            offb_s = {dec_up[1:0], `OFF_1}; // RQ17
        end
        else
        begin
            kind_s = {`KIND_3D, dec_up[5:4]};
            offa_s = {`OFF_2, dec_up[3:2]};
            offb_s = {`OFF_3, dec_up[1:0]}; // RQ17
        end
        case (amf[1:0]) // RQ11 RQ14
            2'h0:    cmode_s = `CM_C;
            2'h1:    cmode_s = `CM_D;
            2'h2:    cmode_s = `CM_E;
            default:
            begin
                cmode_s = `CM_RES;
                res_s   = 1'b1;
            end
        endcase
    end
end

// section widths of the shared counter
reg [4:0] lo_w;
reg [4:0] mi_w;

always @*
begin
    lo_w = `LW_A;
    mi_w = `MW_AB;
    case (cmode_s)
        `CM_A:
        begin
            lo_w = `LW_A; // RQ6
            mi_w = `MW_AB;
        end
        `CM_B:
        begin
            lo_w = `LW_B; // RQ7
            mi_w = `MW_AB;
        end
        `CM_C:
        begin
            lo_w = `LW_CD; // RQ14
            mi_w = `MW_CE;
        end
        `CM_D:
        begin
            lo_w = `LW_CD; // RQ14
            mi_w = `MW_D;
        end
        `CM_E:
        begin
            lo_w = `LW_E; // RQ14
            mi_w = `MW_CE;
        end
        default:
        begin
            lo_w = `LW_A;
            mi_w = `MW_AB;
        end
    endcase
end

// masks over the low section and the low plus middle sections
wire [4:0]    lm_w    = lo_w + mi_w;
wire [CW-1:0] lo_mask = ~(`ALL_ONES_24 << lo_w);
wire [CW-1:0] lm_mask = ~(`ALL_ONES_24 << lm_w);
wire [CW-1:0] lo_one  = lo_mask + {{(CW-1){1'b0}}, 1'b1};
wire [CW-1:0] lm_one  = lm_mask + {{(CW-1){1'b0}}, 1'b1};

wire lo_zero  = (work_r & lo_mask) == `RST_ZERO_24;
wire lm_zero  = (work_r & lm_mask) == `RST_ZERO_24;
wire all_zero = work_r == `RST_ZERO_24;

wire step      = active_r & i_word_done; // RQ19
wire wrap_lo   = lo_zero & ~lm_zero;
// the final word closes the last run as well, so its offset is added too
wire wrap_hi   = lm_zero; // RQ10 RQ15

// next count: inner run, then middle reload, then outer reload
reg [CW-1:0] work_nxt;

always @*
begin
    work_nxt = work_r;
    if (!lo_zero)
        work_nxt = work_r - {{(CW-1){1'b0}}, 1'b1}; // RQ10 RQ15
    else if (!lm_zero)
        work_nxt = (work_r - lo_one) | (count_r & lo_mask); // RQ15
    else if (!all_zero)
        work_nxt = (work_r - lm_one) | (count_r & lm_mask); // RQ10 RQ15
end

wire wr_ctrl = i_wr && (i_addr == `REG_CTRL);
wire start   = wr_ctrl && i_wdata[`CTRL_EN_BIT];

always @(posedge i_clock or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        ctrl_r   <= {`CTRL_W{1'b0}};
        count_r  <= `RST_ZERO_24;
        work_r   <= `RST_ZERO_24;
        active_r <= 1'b0;
        err_r    <= 1'b0;
        done_r   <= 1'b0;
    end
    else
    begin
        done_r <= 1'b0;
        if (wr_ctrl)
            ctrl_r <= i_wdata[`CTRL_W-1:0]; // RQ1
        if (i_wr && i_addr == `REG_COUNT)
            count_r <= i_wdata[CW-1:0];
        if (start)
        begin
            // reserved encodings are refused rather than guessed at
            active_r <= 1'b0;
            err_r    <= 1'b0;
            work_r   <= count_r;
        end
        else if (wr_ctrl)
        begin
            active_r <= 1'b0;
            err_r    <= 1'b0;
        end
        else if (step)
        begin
            work_r <= work_nxt; // RQ3
            if (all_zero)
            begin
                active_r <= 1'b0;
                done_r   <= 1'b1;
            end
        end
        if (start)
        begin
            // decode follows the new control word one cycle later
            active_r <= 1'b0;
        end
        if (run_pend_r && !wr_ctrl)
        begin
            if (res_s)
                err_r <= 1'b1;
            else
                active_r <= 1'b1;
        end
    end
end

// start is armed one cycle after the control write so decode is settled
always @(posedge i_clock or negedge i_nrst)
begin
    if (!i_nrst)
        run_pend_r <= 1'b0;
    else
        run_pend_r <= start;
end

// four offset registers
genvar g;

generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_off
        localparam [3:0] IDX = g;
        always @(posedge i_clock or negedge i_nrst)
        begin
            if (!i_nrst)
                off_r[g] <= `RST_ZERO_24;
            else if (i_wr && i_addr == `REG_OFFSET_0 + IDX)
                off_r[g] <= i_wdata[AW-1:0]; // RQ18
        end
    end
endgenerate

// per-side address registers, source then destination
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_side
        localparam [3:0] IDX = g;
        wire [AW-1:0] next;
        wire [1:0]    ia = offa_s[2*g +: 2];
        wire [1:0]    ib = offb_s[2*g +: 2];

        addr_stepper #(.AW(AW)) u_step
        (
            .i_kind    (kind_s[2*g +: 2]),
            .i_addr    (addr_r[g]),
            .i_off_a   (off_r[ia]), // RQ16 RQ17
            .i_off_b   (off_r[ib]),
            .i_wrap_lo (wrap_lo),
            .i_wrap_hi (wrap_hi),
            .o_next    (next)
        );

        always @(posedge i_clock or negedge i_nrst)
        begin
            if (!i_nrst)
                addr_r[g] <= `RST_ZERO_24;
            else if (i_wr && i_addr == `REG_SRC_ADDR + IDX)
                addr_r[g] <= i_wdata[AW-1:0];
            else if (step)
                addr_r[g] <= next; // RQ19
        end
    end
endgenerate

// read data stands only in the cycle after the strobe
reg [23:0] rd_mux;

always @*
begin
    rd_mux = `RST_ZERO_24;
    if (i_addr == `REG_CTRL)
        rd_mux = {16'h0000, active_r, ctrl_r};
    else if (i_addr >= `REG_OFFSET_0 && i_addr < `REG_SRC_ADDR)
        rd_mux = off_r[i_addr[1:0] - `OFF_1]; // RQ18
    else if (i_addr == `REG_SRC_ADDR)
        rd_mux = addr_r[0];
    else if (i_addr == `REG_DST_ADDR)
        rd_mux = addr_r[1];
    else if (i_addr == `REG_COUNT)
        rd_mux = work_r;
    else if (i_addr == `REG_STATUS)
        rd_mux = {15'h0000, kind_s, cmode_s, err_r, active_r};
end

always @(posedge i_clock or negedge i_nrst)
begin
    if (!i_nrst)
        rdata_r <= `RST_ZERO_24;
    else if (i_rd)
        rdata_r <= rd_mux;
    else
        rdata_r <= `RST_ZERO_24;
end

assign o_rdata    = rdata_r;
assign o_src_addr = addr_r[0];
assign o_dst_addr = addr_r[1];
assign o_active   = active_r;
assign o_done     = done_r;

endmodule
`default_nettype wire

// ### test/dma_addr_checker.sv
// port checker for the dma address generator
`timescale 1ns/100ps
`default_nettype none
module dma_addr_checker
#(
    parameter AW = 24,
    parameter CW = 24
)
(
    input wire logic          i_clock,
    input wire logic          i_nrst,
    input wire logic [3:0]    i_addr,
    input wire logic [23:0]   i_wdata,
    input wire logic          i_wr,
    input wire logic          i_rd,
    input wire logic [23:0]   o_rdata,
    input wire logic          i_word_done,
    input wire logic [AW-1:0] o_src_addr,
    input wire logic [AW-1:0] o_dst_addr,
    input wire logic          o_active,
    input wire logic          o_done
);
    logic [6:0] mode_r;
    logic       ctl_w;
    logic       step;
    assign ctl_w = i_wr && i_addr == 4'h0;
    assign step = o_active && i_word_done && !i_wr;
    // last written mode, so per-side checks know the decode
    always @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            mode_r <= 7'h00;
        else if (ctl_w)
            mode_r <= i_wdata[6:0];
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 24'h00_0000)
        else $error("read data outside its cycle");
    a_done_single: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    a_done_cause: assert property ($rose(o_done) |-> $past(i_word_done) && !o_active)
        else $error("done without a final word");
    a_start_delay: assert property ($rose(o_active) |-> $past(ctl_w, 2))
        else $error("start not two cycles after control write");
    a_addr_quiet: assert property (!step && !i_wr |=> $stable(o_src_addr) && $stable(o_dst_addr))
        else $error("address moved without a word");
    a_src_hold: assert property (step && !mode_r[6] && mode_r[2:0] == 3'h4 |=> $stable(o_src_addr))
        else $error("held source moved");
    a_dst_inc: assert property (step && !(mode_r[6] && mode_r[2]) && mode_r[5:3] == 3'h5
        |=> o_dst_addr == $past(o_dst_addr) + 1'b1)
        else $error("destination did not step by one");
    a_reserved_idle: assert property (ctl_w && (i_wdata[2:1] == 2'h3 && !i_wdata[6]
        || i_wdata[5:4] == 2'h3 && !i_wdata[6] || i_wdata[6] && i_wdata[1:0] == 2'h3)
        |=> !o_active [*3])
        else $error("reserved decode started");
endmodule
bind dma_address_generator dma_addr_checker #(.AW(AW), .CW(CW)) u_chk
(
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_word_done(i_word_done),
    .o_src_addr(o_src_addr), .o_dst_addr(o_dst_addr), .o_active(o_active),
    .o_done(o_done)
);
`default_nettype wire

// ### test/word_seq_model.sv
// behavioural transfer sequencer pacing word completions
`timescale 1ns/100ps
`default_nettype none
module word_seq_model
(
    input  wire logic i_clock,
    input  wire logic i_nrst,
    input  wire logic i_enable,
    input  wire logic i_slow,
    input  wire logic i_active,
    output logic      o_word_done
);
    // sees active one edge late, so one stray pulse follows the last word unless i_slow is set
    always @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            o_word_done <= 1'b0;
        else
            o_word_done <= i_enable && i_active && !(i_slow && o_word_done);
    end
endmodule
`default_nettype wire

// ### test/dma_address_generator_tb_top.sv
// self-checking bench for the dma address generator
`timescale 1ns/100ps
`default_nettype none
module dma_address_generator_tb_top;
    logic        i_clock = 1'b0;
    logic        i_nrst = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [23:0] i_wdata = 24'h00_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        go = 1'b0;
    logic        slow = 1'b0;
    wire  [23:0] o_rdata;
    wire         word_done;
    wire  [23:0] o_src_addr;
    wire  [23:0] o_dst_addr;
    wire         o_active;
    wire         o_done;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [23:0] rd_v;
    logic [23:0] offs [4] = '{24'h00_0010, 24'h00_0100, 24'h00_0020, 24'h00_0200};
    logic [6:0]  tm [8] = '{7'h2c, 7'h29, 7'h68, 7'h65, 7'h52, 7'h78, 7'h74, 7'h03};
    logic [23:0] tc [8] = '{24'h00_0003, 24'h00_1002, 24'h00_0041, 24'h00_0041, 24'h00_1002,
                            24'h00_0041, 24'h00_0041, 24'h00_1002};
    logic [23:0] ts [8] = '{24'h00_0100, 24'h00_0304, 24'h00_0212, 24'h00_0100, 24'h00_0214,
                            24'h00_0212, 24'h00_0212, 24'h00_0504};
    logic [23:0] td [8] = '{24'h00_0204, 24'h00_0206, 24'h00_0204, 24'h00_0422, 24'h00_0244,
                            24'h00_0422, 24'h00_0422, 24'h00_0224};
    logic [8:0]  tt [8] = '{9'h080, 9'h0c4, 9'h0e8, 9'h18c, 9'h170, 9'h1e8, 9'h1e8, 9'h144};
    logic [6:0]  bad [3] = '{7'h06, 7'h30, 7'h43};

    dma_address_generator u_dut
    (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_word_done(word_done),
        .o_src_addr(o_src_addr), .o_dst_addr(o_dst_addr), .o_active(o_active),
        .o_done(o_done)
    );
    word_seq_model u_seq
    (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_enable(go), .i_slow(slow),
        .i_active(o_active), .o_word_done(word_done)
    );

    always #2 i_clock = ~i_clock;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            summarize;
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask

    // loads addresses and count, starts, waits for the final word
    task automatic run(input int t);
        wr(4'h5, 24'h00_0100);
        wr(4'h6, 24'h00_0200);
        wr(4'h7, tc[t]);
        wr(4'h0, {16'h0000, 1'b1, tm[t]});
        go <= 1'b1;
        for (int k = 0; k < 300; k++)
        begin
            @(posedge i_clock);
            if (o_done === 1'b1)
                break;
        end
        go <= 1'b0;
        check(o_done, 1'b1);
    endtask

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(i + 1));
            check(rd_v, 24'h00_0000);
            wr(4'(i + 1), offs[i]);
        end
        wr(4'hc, 24'hff_ffff);
        rd(4'hc);
        check(rd_v, 24'h00_0000);
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(i + 1));
            check(rd_v, offs[i]);
        end
        $display("test registers done");
        for (int t = 0; t < 8; t++)
        begin
            slow <= t[0];
            run(t);
            check(o_src_addr, ts[t]);
            check(o_dst_addr, td[t]);
            rd(4'h8);
            check(rd_v, {15'h0000, tt[t]});
            $display("test transfer %0d done", t);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(4'h0, {16'h0000, 1'b1, bad[i]});
            repeat (3) @(posedge i_clock);
            check(o_active, 1'b0);
            rd(4'h8);
            check(rd_v[1], 1'b1);
        end
        $display("test reserved done");
        wr(4'h7, 24'h00_0100);
        wr(4'h0, 24'h00_00ad);
        go <= 1'b1;
        repeat (10) @(posedge i_clock);
        check(o_active, 1'b1);
        rd(4'h0);
        check(rd_v, 24'h00_00ad);
        wr(4'h0, 24'h00_002d);
        repeat (3) @(posedge i_clock);
        check(o_active, 1'b0);
        rd(4'h0);
        check(rd_v, 24'h00_002d);
        rd_v = o_src_addr;
        repeat (5) @(posedge i_clock);
        check(o_src_addr, rd_v);
        go <= 1'b0;
        $display("test stop done");
        summarize;
    end
endmodule
`default_nettype wire
